/* cps_pkg.sv */
// shared constants and types of the codec process sequencer
package cps_pkg;

  // ---------------------------------------------------------------
  // strip and code buffer figures
  // ---------------------------------------------------------------
  localparam int LOW_FILL_PIXELS   = 16;    // nearly empty margin, pixels
  localparam int FIRST_STRIP_LINES = 8;     // lines in the first strip
  localparam int DEF_LINE_PIXELS   = 720;   // active pixels per line
  localparam int DEF_STRIP_PIXELS  = 16384; // strip buffer capacity
  localparam int DEF_NEAR_FULL     = 64;    // near full margin, pixels
  localparam int DEF_PIX_W         = 15;    // width of the fill count
  localparam int DEF_CODE_W        = 8;     // compressed code width
  localparam int BUF_ENTRIES       = 2;     // entries in the code buffer

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic FLAG_OFF_N = 1'b1;  // inactive level of low flags
  localparam logic FLAG_OFF   = 1'b0;  // inactive level of high flags

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CPS_COMPRESS, CPS_STATISTICAL, CPS_AUTO_TWO_PASS, CPS_TABLES_ONLY, CPS_DECOMPRESS
  } cps_mode_t;

  typedef enum logic [3:0] {
    CPS_IDLE, CPS_ARM, CPS_STAT_RUN, CPS_PASS2_WAIT, CPS_COMP_RUN,
    CPS_TABLES_RUN, CPS_DEC_ARM, CPS_DEC_RUN, CPS_AWAIT_SERVICE
  } cps_state_t;

endpackage

/* cps_stream_if.sv */
// valid/ready stream carrier between sequencer and code buffer
`timescale 1ns/10ps
interface cps_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;   // payload
  logic         valid;  // payload present
  logic         ready;  // sink takes payload

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* cps_code_buf.sv */
// two-entry code buffer between the code bus and the decoder
`timescale 1ns/10ps
module cps_code_buf #(
  parameter int W = cps_pkg::DEF_CODE_W
) (
  input  wire logic core_clk,  // system clock
  input  wire logic reset,     // synchronous reset, high
  input  wire logic clk_en,    // freezes all state when low
  cps_stream_if.snk up,        // from code bus
  cps_stream_if.src dn         // to decoder
);
  import cps_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [W-1:0] mem [BUF_ENTRIES];
  logic [W-1:0] next_mem [BUF_ENTRIES];
  logic         wr_idx, next_wr_idx;
  logic         rd_idx, next_rd_idx;
  logic [1:0]   count, next_count;
  logic         push, pop;

  // handshakes gated by clk_en so no word moves while frozen
  always_comb begin
    up.ready    = clk_en && (count != 2'h2);
    dn.valid    = clk_en && (count != 2'h0);
    dn.data     = mem[rd_idx];
    push        = up.valid && up.ready;
    pop         = dn.valid && dn.ready;
    next_mem    = mem;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count  = count;
    if (push) begin
      next_mem[wr_idx] = up.data;
      next_wr_idx      = ~wr_idx;
    end
    if (pop) begin
      next_rd_idx = ~rd_idx;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count  <= 2'h0;
    end else if (clk_en) begin
      mem    <= next_mem;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count  <= next_count;
    end
  end

endmodule // cps_code_buf

/* cps_sequencer.sv */
// process-level sequencer for compression and decompression passes
// Contract
// - auto mode: statistical then compression, no done between
// - second pass starts at next vsync unconditionally
// - start sampled only in idle, none between passes
// - tables pass emits no frame, scan, entropy
// - tables pass started by start, then done, idle
// - idle: background shown, slave hold asserted
// - after decompress start fetch and decode code
// - no pixels out before selected vsync
// - decompress start releases hold, asserts low fill
// - low fill released once output can begin
// - strip near full halts pixels, backpressures code
// - decompress done at later of eoi, area end
// - corruption flagged at once, process still completes
// - corruption cleared with done on next start
// - masked corruption: back to idle sampling start
// - enabled corruption: irq, then frozen await service
// - decompress strip underflow flags corruption
// - fill first strip then stop until active
// - odd-field start waits odd vsync, else next
// - statistical pass writes no code, no hold
// - compress overflow or early vsync flags corruption
// - low fill means within sixteen pixels of underflow
`timescale 1ns/10ps
module cps_sequencer #(
  parameter int CODE_W       = cps_pkg::DEF_CODE_W,       // code word width
  parameter int LINE_PIXELS  = cps_pkg::DEF_LINE_PIXELS,  // pixels per line
  parameter int STRIP_PIXELS = cps_pkg::DEF_STRIP_PIXELS, // strip capacity
  parameter int NEAR_FULL    = cps_pkg::DEF_NEAR_FULL,    // near full margin
  parameter int PIX_W        = cps_pkg::DEF_PIX_W         // fill count width
) (
  input  wire logic              core_clk,        // system clock
  input  wire logic              reset,           // sync reset, high
  input  wire logic              clk_en,          // freezes state when low
  input  wire logic              start_n,         // start request, low
  input  wire logic              odd_field_n,     // odd-field qualifier, low
  input  wire cps_pkg::cps_mode_t mode_sel,       // process mode
  input  wire logic              code_master,     // 1: device masters code bus
  input  wire logic              corrupt_irq_en,  // corruption raises irq
  input  wire logic              irq_status_read, // host reads irq status
  input  wire logic              vsync,           // vertical sync level
  input  wire logic              field_edge_select, // 1 rising, 0 falling
  input  wire logic              odd_field_ind,   // current field is odd
  input  wire logic              stat_done,       // statistical pass over
  input  wire logic              comp_done,       // field compressed
  input  wire logic              tables_done,     // tables emitted
  input  wire logic              eoi_seen,        // decoder saw end of image
  input  wire logic              active_start,    // active area begins
  input  wire logic              active_end,      // active area over
  input  wire logic              line_due,        // first line of strip due
  input  wire logic              strip_overflow,  // strip overflow in encode
  input  wire logic [PIX_W-1:0]  strip_pixels,    // strip buffer fill
  input  wire logic              code_in_valid,   // code word offered
  input  wire logic [CODE_W-1:0] code_in_data,    // code word
  output logic                   code_in_ready,   // code word taken
  output logic                   code_fetch_en,   // master: fetch allowed
  output logic                   code_flow_hold_n,// slave: hold, low
  output logic                   dec_code_valid,  // code to decoder
  output logic [CODE_W-1:0]      dec_code_data,   // code to decoder
  input  wire logic              dec_code_ready,  // decoder takes code
  output logic                   process_done_n,  // completion, low
  output logic                   data_corrupt_n,  // corruption, low
  output logic                   host_irq,        // interrupt to host
  output logic                   strip_low_fill_n,// strip nearly empty, low
  output logic                   video_out_en,    // pixels on video bus
  output logic                   background_en,   // background colour out
  output logic                   code_write_en,   // encoder writes code
  output logic                   entropy_en,      // frame/scan/entropy on
  output logic                   tables_only_run, // tables-only segments
  output logic                   rate_update      // rate results update
);
  import cps_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (STRIP_PIXELS >= 2**PIX_W || CODE_W < 1 ||
      LINE_PIXELS * FIRST_STRIP_LINES + NEAR_FULL > STRIP_PIXELS) begin : g_bad
    $error("cps_sequencer: strip parameters cannot be served");
  end

  localparam logic [PIX_W-1:0] FIRST_FILL = PIX_W'(LINE_PIXELS * FIRST_STRIP_LINES);
  localparam logic [PIX_W-1:0] LINE_PIX   = PIX_W'(LINE_PIXELS);
  localparam logic [PIX_W-1:0] LOW_MARK   = PIX_W'(LOW_FILL_PIXELS);
  localparam logic [PIX_W-1:0] HALT_MARK  = PIX_W'(STRIP_PIXELS - NEAR_FULL);

  function automatic logic dec_state(input cps_state_t s);
    return (s == CPS_DEC_ARM) || (s == CPS_DEC_RUN);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cps_state_t state, next_state;
  cps_mode_t  mode, next_mode;
  logic want_odd, next_want_odd;
  logic next_done_n, next_corrupt_n, next_host_irq, next_rate_update;
  logic vsync_q;
  logic eoi_flag, next_eoi_flag;
  logic area_flag, next_area_flag;
  logic fill_done, next_fill_done;
  logic active_on, next_active_on;
  logic field_edge, wait_edge, corrupt_evt, strip_halt, code_gate, finish;

  // field edge picked by the edge select; odd field gates the odd wait
  assign field_edge = field_edge_select ? (vsync & ~vsync_q) : (~vsync & vsync_q);
  assign wait_edge  = field_edge && (!want_odd || odd_field_ind);

  // corruption sources by process kind
  assign corrupt_evt =
    ((state == CPS_COMP_RUN) && (strip_overflow || field_edge)) ||
    ((state == CPS_DEC_RUN) && line_due && (strip_pixels < LINE_PIX));

  // sequencing and flags
  always_comb begin
    next_state       = state;
    next_mode        = mode;
    next_want_odd    = want_odd;
    next_done_n      = process_done_n;
    next_corrupt_n   = data_corrupt_n;
    next_host_irq    = host_irq;
    next_rate_update = 1'b0;
    next_eoi_flag    = eoi_flag;
    next_area_flag   = area_flag;
    next_fill_done   = fill_done;
    next_active_on   = active_on;
    finish           = 1'b0;
    case (state)
      CPS_IDLE: begin
        // start looked at only here, once per clock; held or pulsed alike
        if (!start_n) begin
          next_done_n    = FLAG_OFF_N;
          next_corrupt_n = FLAG_OFF_N;
          next_mode      = mode_sel;
          next_want_odd  = !odd_field_n;
          next_eoi_flag  = 1'b0;
          next_area_flag = 1'b0;
          next_fill_done = 1'b0;
          next_active_on = 1'b0;
          next_state     = (mode_sel == CPS_DECOMPRESS) ? CPS_DEC_ARM : CPS_ARM;
        end
      end
      CPS_ARM: begin
        if (wait_edge) begin
          case (mode)
            CPS_STATISTICAL, CPS_AUTO_TWO_PASS: next_state = CPS_STAT_RUN;
            CPS_TABLES_ONLY:                    next_state = CPS_TABLES_RUN;
            default:                            next_state = CPS_COMP_RUN;
          endcase
        end
      end
      CPS_STAT_RUN: begin
        if (stat_done) begin
          next_rate_update = 1'b1;
          if (mode == CPS_AUTO_TWO_PASS) begin
            next_state = CPS_PASS2_WAIT;
          end else begin
            finish = 1'b1;
          end
        end
      end
      CPS_PASS2_WAIT: begin
        // start and odd field deliberately not looked at here
        if (field_edge) begin
          next_state = CPS_COMP_RUN;
        end
      end
      CPS_COMP_RUN: begin
        if (comp_done) begin
          next_rate_update = 1'b1;
          finish           = 1'b1;
        end
      end
      CPS_TABLES_RUN: begin
        if (tables_done) begin
          finish = 1'b1;
        end
      end
      CPS_DEC_ARM: begin
        if (wait_edge) begin
          next_state = CPS_DEC_RUN;
        end
      end
      CPS_DEC_RUN: begin
        if (active_start) begin
          next_active_on = 1'b1;
        end
        if (eoi_seen) begin
          next_eoi_flag = 1'b1;
        end
        if (active_end) begin
          next_area_flag = 1'b1;
        end
        // done waits for whichever of the two events comes last
        if ((eoi_flag || eoi_seen) && (area_flag || active_end)) begin
          finish = 1'b1;
        end
      end
      CPS_AWAIT_SERVICE: begin
        // frozen: start ignored until the host reads its status
        if (irq_status_read) begin
          next_host_irq = FLAG_OFF;
          next_state    = CPS_IDLE;
        end
      end
      default: next_state = CPS_IDLE;
    endcase
    // the first strip counts as filled once eight lines are present
    if (dec_state(state) && (strip_pixels >= FIRST_FILL)) begin
      next_fill_done = 1'b1;
    end
    // set after any clear so a same-cycle event is never lost
    if (corrupt_evt) begin
      next_corrupt_n = 1'b0;
      if (corrupt_irq_en) begin
        next_host_irq = 1'b1;
      end
    end
    if (finish) begin
      next_done_n = 1'b0;
      next_state  = next_host_irq ? CPS_AWAIT_SERVICE : CPS_IDLE;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state          <= CPS_IDLE;
      mode           <= CPS_COMPRESS;
      want_odd       <= 1'b0;
      process_done_n <= FLAG_OFF_N;
      data_corrupt_n <= FLAG_OFF_N;
      host_irq       <= FLAG_OFF;
      rate_update    <= FLAG_OFF;
      vsync_q        <= 1'b0;
      eoi_flag       <= 1'b0;
      area_flag      <= 1'b0;
      fill_done      <= 1'b0;
      active_on      <= 1'b0;
    end else if (clk_en) begin
      state          <= next_state;
      mode           <= next_mode;
      want_odd       <= next_want_odd;
      process_done_n <= next_done_n;
      data_corrupt_n <= next_corrupt_n;
      host_irq       <= next_host_irq;
      rate_update    <= next_rate_update;
      vsync_q        <= vsync;
      eoi_flag       <= next_eoi_flag;
      area_flag      <= next_area_flag;
      fill_done      <= next_fill_done;
      active_on      <= next_active_on;
    end
  end

  // ---------------------------------------------------------------
  // code path
  // ---------------------------------------------------------------
  cps_stream_if #(.W(CODE_W)) cin ();
  cps_stream_if #(.W(CODE_W)) cout ();

  cps_code_buf #(.W(CODE_W)) u_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .up       (cin),
    .dn       (cout)
  );

  // code flows while decoding, paused after first strip until active
  assign code_gate     = dec_state(state) && (!fill_done || active_on);
  assign cin.valid     = code_in_valid && code_gate;
  assign cin.data      = code_in_data;
  assign code_in_ready = cin.ready && code_gate;
  assign code_fetch_en = code_master && code_in_ready;

  // near full halts the decoder; the buffer then fills and holds code
  assign strip_halt     = (strip_pixels >= HALT_MARK);
  assign cout.ready     = dec_code_ready && !strip_halt;
  assign dec_code_valid = cout.valid && !strip_halt;
  assign dec_code_data  = cout.data;

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  // slave hold: held in idle, arm and await service, follows the buffer when decoding
  always_comb begin
    if (code_master) begin
      code_flow_hold_n = 1'b1;
    end else if (dec_state(state)) begin
      code_flow_hold_n = code_in_ready;
    end else begin
      code_flow_hold_n = (state == CPS_STAT_RUN) || (state == CPS_PASS2_WAIT) ||
                         (state == CPS_COMP_RUN) || (state == CPS_TABLES_RUN);
    end
  end

  // low fill until first strip is there, then on the 16-pixel margin
  assign strip_low_fill_n = !dec_state(state) ||
                            (fill_done && (strip_pixels > LOW_MARK));
  assign video_out_en     = (state == CPS_DEC_RUN);
  assign background_en    = !video_out_en;
  assign code_write_en    = (state == CPS_COMP_RUN) || (state == CPS_TABLES_RUN);
  assign entropy_en       = (state == CPS_COMP_RUN) || (state == CPS_STAT_RUN);
  assign tables_only_run  = (state == CPS_TABLES_RUN);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_IDLE_HOLD: assert property (state == CPS_IDLE && !code_master |-> !code_flow_hold_n)
    else $error("hold not asserted in idle");
  AST_START_CLEARS: assert property (clk_en && state == CPS_IDLE && !start_n |=>
    process_done_n && data_corrupt_n && state != CPS_IDLE)
    else $error("start did not clear done and corruption");
  AST_CORRUPT_SET: assert property (clk_en && corrupt_evt |=>
    !data_corrupt_n && (host_irq == ($past(corrupt_irq_en) || $past(host_irq))))
    else $error("corruption event not flagged");
  AST_AWAIT_FROZEN: assert property (clk_en && state == CPS_AWAIT_SERVICE &&
    !irq_status_read |=> state == CPS_AWAIT_SERVICE && host_irq)
    else $error("await service left without status read");
  AST_IRQ_RELEASE: assert property (clk_en && state == CPS_AWAIT_SERVICE &&
    irq_status_read |=> !host_irq && state == CPS_IDLE)
    else $error("irq not released on status read");
  AST_PASS2: assert property (clk_en && state == CPS_PASS2_WAIT && field_edge |=>
    state == CPS_COMP_RUN && process_done_n)
    else $error("second pass not started at vsync");
  AST_NO_DONE_BETWEEN: assert property (clk_en && state == CPS_STAT_RUN && stat_done &&
    mode == CPS_AUTO_TWO_PASS |=> process_done_n [*2])
    else $error("done raised between passes");
  AST_NO_EARLY_VIDEO: assert property (state == CPS_DEC_ARM |-> !video_out_en)
    else $error("pixels out before vsync");
  AST_STAT_QUIET: assert property (state == CPS_STAT_RUN |->
    !code_write_en && (code_master || code_flow_hold_n))
    else $error("statistical pass touched code");
  AST_TABLES_ONLY: assert property (tables_only_run |-> !entropy_en)
    else $error("entropy segments in tables pass");
  AST_DEC_DONE: assert property (clk_en && state == CPS_DEC_RUN &&
    (eoi_flag || eoi_seen) && (area_flag || active_end) |=> !process_done_n)
    else $error("decompression done missed");
  AST_LOW_FILL: assert property (state == CPS_DEC_RUN && strip_pixels <= LOW_MARK |->
    !strip_low_fill_n)
    else $error("low fill not shown near underflow");
  AST_HALT: assert property (strip_halt |-> !dec_code_valid && !cout.ready)
    else $error("pixels not halted near full");

  COV_AUTO: cover property (state == CPS_PASS2_WAIT ##[1:1000] state == CPS_COMP_RUN);
  COV_AWAIT: cover property (state == CPS_AWAIT_SERVICE ##1 state == CPS_IDLE);
  COV_DEC: cover property (state == CPS_DEC_RUN ##1 !process_done_n);
  COV_TABLES: cover property (state == CPS_TABLES_RUN ##1 state == CPS_IDLE);

endmodule // cps_sequencer

/* cps_host_model.sv */
// host-side model that offers compressed code words to the sequencer
`timescale 1ns/10ps
module cps_host_model #(
  parameter int W = 8  // word width
) (
  input  wire logic         core_clk,  // system clock
  input  wire logic         reset,     // sync reset, high
  input  wire logic         stall,     // hold back new words
  input  wire logic         ready,     // device takes word
  output logic              valid,     // word offered
  output logic [W-1:0]      data       // offered word
);
  logic [W-1:0] cnt;  // next word to offer

  // offer held until taken; idle data toggles so a stale word never matches
  always_ff @(posedge core_clk) begin
    if (reset) begin
      valid <= 1'b0;
      data  <= '1;
      cnt   <= '0;
    end else if (!valid || ready) begin
      valid <= !stall;
      data  <= stall ? ~data : cnt;
      cnt   <= stall ? cnt : cnt + 1'b1;
    end
  end
endmodule // cps_host_model

/* codec_process_sequencer_tb.sv */
// self-checking bench of the codec process sequencer
`timescale 1ns/10ps
module codec_process_sequencer_tb;
  import cps_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic core_clk, reset, start_n, code_master, irq_en, irq_rd, vsync, stat_done, comp_done;
  logic tables_done, eoi_seen, act_start, act_end, line_due, cv, cr, fetch, hold_n, dv, dr;
  logic done_n, corrupt_n, host_irq, low_n, video, bg, wr, ent, tab, rate;
  logic clk_en, odd_n, edge_sel, odd_ind, ovf, stall;
  logic [7:0] cd, dd, strip;
  cps_mode_t mode_sel;
  int failures = 0;
  int check_count = 0;
  cps_sequencer #(.LINE_PIXELS(4), .STRIP_PIXELS(128), .NEAR_FULL(16), .PIX_W(8)) i_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .start_n(start_n),
    .odd_field_n(odd_n), .mode_sel(mode_sel), .code_master(code_master),
    .corrupt_irq_en(irq_en), .irq_status_read(irq_rd), .vsync(vsync),
    .field_edge_select(edge_sel), .odd_field_ind(odd_ind),
    .stat_done(stat_done), .comp_done(comp_done), .tables_done(tables_done),
    .eoi_seen(eoi_seen), .active_start(act_start), .active_end(act_end), .line_due(line_due),
    .strip_overflow(ovf), .strip_pixels(strip), .code_in_valid(cv), .code_in_data(cd),
    .code_in_ready(cr), .code_fetch_en(fetch), .code_flow_hold_n(hold_n), .dec_code_valid(dv),
    .dec_code_data(dd), .dec_code_ready(dr), .process_done_n(done_n),
    .data_corrupt_n(corrupt_n), .host_irq(host_irq), .strip_low_fill_n(low_n),
    .video_out_en(video), .background_en(bg), .code_write_en(wr), .entropy_en(ent),
    .tables_only_run(tab), .rate_update(rate));
  cps_host_model #(.W(8)) i_host (.core_clk(core_clk), .reset(reset), .stall(stall),
    .ready(cr), .valid(cv), .data(cd));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // bounded wait: 0 any run flag, nonzero decoder word present
  task automatic wait_for(input int b);
    int n;
    n = 0;
    while (((b != 0) ? dv : (wr | ent | tab | video)) !== 1'b1) begin
      tick();
      n++;
      if (n > 40) begin
        chk("wait", 3'h1, 3'h0);
        conclude();
      end
    end
  endtask
  task automatic vs_rise;
    vsync = 1'b0;
    tick();
    vsync = 1'b1;
    tick();
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  cps_mode_t modes[4] = '{CPS_COMPRESS, CPS_STATISTICAL, CPS_AUTO_TWO_PASS, CPS_TABLES_ONLY};
  logic [2:0] flags[4] = '{3'h6, 3'h2, 3'h2, 3'h5};  // write, entropy, tables
  initial begin
    {start_n, reset} = 2'b11;
    {code_master, irq_en, irq_rd, vsync, stat_done, comp_done, tables_done} = '0;
    {eoi_seen, act_start, act_end, line_due, dr} = '0;
    strip = 8'h00;
    {clk_en, odd_n, edge_sel, odd_ind, ovf, stall} = 6'b111000;
    mode_sel = CPS_COMPRESS;
    tick(4);
    reset = 1'b0;
    chk("idle", 3'h4, {done_n, corrupt_n, host_irq} ^ 3'h2);
    chk("hold_bg", 3'h1, {hold_n, bg});
    code_master = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mode_sel = modes[i];
      start_n = 1'b0;
      tick();
      start_n = 1'b1;
      chk("arm_done", 3'h1, done_n);
      vs_rise();
      wait_for(0);
      chk("run_flags", flags[i], {wr, ent, tab});
      {stat_done, tables_done, comp_done} = {i == 1 || i == 2, i == 3, i == 0};
      tick();
      {stat_done, tables_done, comp_done} = '0;
      if (i == 2) begin
        chk("pass1_done", 3'h1, done_n);
        vs_rise();
        chk("pass2", 3'h6, {wr, ent, tab});
        comp_done = 1'b1;
        tick();
        comp_done = 1'b0;
      end
      chk("done", 3'h0, done_n);
      chk("rate", {2'b00, i != 3}, rate);
    end
    // odd-field start on the falling edge, frozen clock, masked overflow
    mode_sel = CPS_COMPRESS;
    {odd_n, edge_sel, start_n} = 3'b000;
    tick();
    {start_n, vsync} = 2'b10;
    tick();
    chk("odd_wait", 3'h0, wr);
    {odd_ind, vsync} = 2'b11;
    tick();
    vsync = 1'b0;
    tick();
    chk("odd_run", 3'h6, {wr, ent, tab});
    {clk_en, comp_done} = 2'b01;
    tick();
    {clk_en, comp_done, ovf} = 3'b101;
    chk("frozen_clk", 3'h1, done_n);
    tick();
    {ovf, comp_done} = 2'b01;
    chk("overflow", 3'h0, {corrupt_n, host_irq});
    tick();
    comp_done = 1'b0;
    chk("masked_done", 3'h0, {done_n, corrupt_n, host_irq});
    // decompression with corruption, interrupt and held start
    mode_sel = CPS_DECOMPRESS;
    {code_master, irq_en, dr, odd_n, edge_sel, start_n} = 6'b011110;
    tick();
    chk("dec_arm", 3'h1, {low_n, video, hold_n});
    chk("slave_fetch", 3'h0, fetch);
    wait_for(1);
    chk("first_word", 3'h0, dd[2:0]);
    dr = 1'b0;
    tick(4);
    chk("buf_full", 3'h0, {cr, hold_n});
    strip = 8'd120;
    dr = 1'b1;
    tick();
    chk("near_full", 3'h0, dv);
    strip = 8'd32;
    tick(2);
    chk("strip_ready", 3'h2, {low_n, cr});
    vs_rise();
    wait_for(0);
    chk("video", 3'h1, video);
    {act_start, line_due, strip} = {2'b11, 8'd2};
    tick();
    {act_start, line_due} = '0;
    chk("underflow", 3'h1, {low_n, corrupt_n, host_irq});
    eoi_seen = 1'b1;
    tick();
    {eoi_seen, act_end} = 2'b01;
    chk("eoi_only", 3'h1, done_n);
    tick();
    act_end = 1'b0;
    tick(3);
    chk("frozen", 3'h1, {done_n, host_irq});
    irq_rd = 1'b1;
    tick();
    irq_rd = 1'b0;
    chk("irq_clr", 3'h0, host_irq);
    tick(2);
    chk("restart", 3'h3, {done_n, corrupt_n});
    conclude();
  end
endmodule // codec_process_sequencer_tb
